//--- core/tsr_regs.svh
`ifndef TSR_REGS_SVH
`define TSR_REGS_SVH

// ************************************************************
// Timing figures and clock rate
// ************************************************************
`define TSR_SYS_PERIOD_NS   40
`define TSR_CONV_PERIOD_US  350
`define TSR_CONV_TIME_US    25
`define TSR_GAP_MARGIN_PCT  130
`define TSR_PERIOD_CYC      ((`TSR_CONV_PERIOD_US * 1000) / `TSR_SYS_PERIOD_NS)
`define TSR_CONV_CYC        ((`TSR_CONV_TIME_US * 1000) / `TSR_SYS_PERIOD_NS)
`define TSR_GAP_CYC         ((`TSR_CONV_PERIOD_US * 1000 * `TSR_GAP_MARGIN_PCT \
                              + 100 * `TSR_SYS_PERIOD_NS - 1) \
                             / (100 * `TSR_SYS_PERIOD_NS))

// ************************************************************
// Frame layout
// ************************************************************
`define TSR_DATA_BITS       4'h0_00A
`define TSR_FRAME_CLKS      5'h0_010
`define TSR_SCLK_HALF       3'h0_004
`define TSR_EDGE_GAP        3'h0_004
`define TSR_CTRL_RST        8'h0_000

// ************************************************************
// Host register map
// ************************************************************
`define TSR_OFS_CTRL        8'h0_000
`define TSR_OFS_STATUS      8'h0_004
`define TSR_OFS_DATA        8'h0_008
`define TSR_CTRL_START_BIT  0
`define TSR_ST_BUSY_BIT     0
`define TSR_ST_DONE_BIT     1
`define TSR_ST_GAPOK_BIT    2
`define TSR_ST_PEND_BIT     3
`define TSR_DATA_RAW_LSB    16

`endif

//--- core/tsr_pkg.sv
package tsr_pkg;

    typedef logic [9:0]  tsr_temp_t;
    typedef logic [15:0] tsr_frame_t;

    typedef enum logic {
        TSR_DEV_SLEEP = 1'b0,
        TSR_DEV_CONV  = 1'b1
    } tsr_dev_state_e;

    typedef enum logic [1:0] {
        TSR_HST_IDLE  = 2'b00,
        TSR_HST_LEAD  = 2'b01,
        TSR_HST_SHIFT = 2'b11,
        TSR_HST_TAIL  = 2'b10
    } tsr_hst_state_e;

endpackage : tsr_pkg

//--- core/tsr_if.sv
`timescale 1ns/1ns
interface tsr_if;
    logic sclk;
    logic temp_select_n;
    logic din;
    logic dout;
    logic dout_oe_n;
    logic sdo;

    // The released data line is seen as a weak pull-down.
    assign sdo = dout_oe_n ? 1'b0 : dout;

    modport dev (
        input  sclk,
        input  temp_select_n,
        input  din,
        output dout,
        output dout_oe_n
    );

    modport host (
        output sclk,
        output temp_select_n,
        output din,
        input  sdo
    );
endinterface : tsr_if

//--- core/tsr_sync.sv
`timescale 1ns/1ns
module tsr_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Level in and out
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : tsr_sync

//--- core/tsr_dev.sv
// Behaviour
// R01 - Clock ignored unless temperature select low
// R02 - Leading zero then ten result bits
// R03 - One read is sixteen clocks
// R04 - Hold last bit, release at select high
// R05 - Capture input bits on rising clock
// R06 - Host keeps serial input low
// R07 - Result is quarter-degree twos complement
// R08 - Automatic conversion every 350 us; code sleeps 350 us after each 25 us conversion, so starts are 375 us apart
// R09 - Conversion lasts 25 us, then sleep
// R10 - Output always shows latest completed result
// R11 - Access during conversion locks out update
// R12 - Lockout clears only at next conversion start
// R13 - Access end restarts oscillator and conversion
// R14 - Early read returns previous data
// R15 - Host spaces select falls beyond 455 us
// R16 - Host may keep one or two bytes
// R17 - Host never selects both paths together
// R18 - Result shifted MSB first, then nothing
`timescale 1ns/1ns
`include "tsr_regs.svh"
module tsr_dev #(
    parameter int unsigned PERIOD_CYC = `TSR_PERIOD_CYC
) (
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            sys_rst,
    // Serial link
    tsr_if.dev                   link,
    // Sensor side
    input  wire tsr_pkg::tsr_temp_t temp_in,
    output tsr_pkg::tsr_temp_t   result,
    output logic [7:0]           ctrl_word,
    output logic                 conv_busy,
    output logic                 lockout
);

    // ************************************************************
    // Link domain
    // ************************************************************
    localparam logic [3:0] DATA_BITS = `TSR_DATA_BITS;

    tsr_pkg::tsr_temp_t result_r;
    logic [3:0]         fall_cnt_r;
    logic               dout_r;
    logic [7:0]         ctrl_shift_r;
    wire  [3:0]         bit_idx = DATA_BITS - 4'h0_001 - fall_cnt_r;

    // Select doubles as the frame reset, so the counter starts clean
    // even though the link clock never runs between frames.
    always_ff @(negedge link.sclk or posedge link.temp_select_n) begin
        if (link.temp_select_n) begin                          // [R01]
            fall_cnt_r <= 4'h0_000;
            dout_r     <= 1'b0;                                // [R02]
        end else if (fall_cnt_r != DATA_BITS) begin            // [R18]
            fall_cnt_r <= fall_cnt_r + 4'h0_001;
            dout_r     <= result_r[bit_idx];                   // [R18]
        end
    end

    // The control word keeps the last eight bits of the frame.
    always_ff @(posedge link.sclk) begin
        if (!link.temp_select_n) begin                         // [R01]
            ctrl_shift_r <= {ctrl_shift_r[6:0], link.din};     // [R05]
        end
    end

    assign link.dout      = dout_r;                            // [R04]
    assign link.dout_oe_n = link.temp_select_n;                // [R04]

    // ************************************************************
    // Select synchroniser
    // ************************************************************
    logic sel_n_s;
    logic sel_act_d_r;

    tsr_sync #(
        .RST_VAL (1'b1)
    ) u_sel_sync (
        .clk (sys_clk),
        .rst (sys_rst),
        .d   (link.temp_select_n),
        .q   (sel_n_s)
    );

    wire sel_act    = ~sel_n_s;
    wire access_end = sel_act_d_r & ~sel_act;

    // ************************************************************
    // Conversion sequencer
    // ************************************************************
    localparam logic [13:0] PERIOD_LAST = 14'(PERIOD_CYC - 1);
    localparam logic [13:0] CONV_LAST   = 14'(`TSR_CONV_CYC - 1);

    tsr_pkg::tsr_dev_state_e state_r;
    logic [13:0]             timer_r;
    logic                    lockout_r;
    logic [7:0]              ctrl_word_r;

    wire osc_timeout = (state_r == tsr_pkg::TSR_DEV_SLEEP)
                     && (timer_r == PERIOD_LAST);              // [R08]
    wire conv_start  = osc_timeout | access_end;               // [R13]
    wire conv_done   = (state_r == tsr_pkg::TSR_DEV_CONV)
                     && (timer_r == CONV_LAST);                // [R09]
    // The result only moves while no frame is open, so the link
    // domain reads it as a stable word without a handshake.
    wire result_upd  = conv_done & ~access_end & ~lockout_r
                     & ~sel_act;                               // [R11]

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sel_act_d_r <= 1'b0;
        end else begin
            sel_act_d_r <= sel_act;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r <= tsr_pkg::TSR_DEV_SLEEP;
            timer_r <= 14'h0_000;
        end else if (conv_start) begin
            state_r <= tsr_pkg::TSR_DEV_CONV;                  // [R13]
            timer_r <= 14'h0_000;
        end else if (conv_done) begin
            state_r <= tsr_pkg::TSR_DEV_SLEEP;                 // [R09]
            timer_r <= 14'h0_000;
        end else begin
            timer_r <= timer_r + 14'h0_001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lockout_r <= 1'b0;
        end else if (conv_start) begin
            lockout_r <= sel_act;                              // [R12]
        end else if (sel_act && state_r == tsr_pkg::TSR_DEV_CONV) begin
            lockout_r <= 1'b1;                                 // [R11]
        end
    end

    // Samples are taken as already coded, a quarter degree per count.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            result_r <= 10'h0_000;
        end else if (result_upd) begin
            result_r <= temp_in;                               // [R07] [R10]
        end
    end

    // The link clock is still when select rises, so the shifted
    // word is quiet by the time the synchronised edge arrives.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_word_r <= `TSR_CTRL_RST;
        end else if (access_end) begin
            ctrl_word_r <= ctrl_shift_r;                       // [R05]
        end
    end

    assign result    = result_r;                               // [R14]
    assign ctrl_word = ctrl_word_r;
    assign conv_busy = (state_r == tsr_pkg::TSR_DEV_CONV);
    assign lockout   = lockout_r;

endmodule : tsr_dev

//--- core/tsr_host.sv
`timescale 1ns/1ns
`include "tsr_regs.svh"
module tsr_host #(
    parameter int unsigned GAP_CYC = `TSR_GAP_CYC
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Serial link
    tsr_if.host              link,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);

    // ************************************************************
    // Register access decode
    // ************************************************************
    wire setup    = psel & ~penable;
    wire access   = psel & penable;
    wire hit_ctrl = (paddr == `TSR_OFS_CTRL);
    wire hit_stat = (paddr == `TSR_OFS_STATUS);
    wire hit_data = (paddr == `TSR_OFS_DATA);
    wire hit      = hit_ctrl | hit_stat | hit_data;
    wire wr_start = access & pwrite & hit_ctrl
                  & pwdata[`TSR_CTRL_START_BIT];
    wire wr_clr   = access & pwrite & hit_stat
                  & pwdata[`TSR_ST_DONE_BIT];

    // ************************************************************
    // Frame sequencer
    // ************************************************************
    localparam logic [14:0] GAP_LAST = 15'(GAP_CYC);

    tsr_pkg::tsr_hst_state_e state_r;
    logic [2:0]              div_r;
    logic [4:0]              edge_cnt_r;
    logic                    sclk_r;
    logic                    sel_n_r;
    logic [14:0]             gap_r;
    logic                    pend_r;
    logic                    done_r;
    tsr_pkg::tsr_frame_t     raw_r;
    tsr_pkg::tsr_frame_t     frame_r;
    logic                    sdo_s;
    logic [31:0]             prdata_r;

    tsr_sync #(
        .RST_VAL (1'b0)
    ) u_sdo_sync (
        .clk (sys_clk),
        .rst (sys_rst),
        .d   (link.sdo),
        .q   (sdo_s)
    );

    wire gap_ok   = (gap_r == GAP_LAST);                       // [R15]
    wire idle     = (state_r == tsr_pkg::TSR_HST_IDLE);
    wire go       = idle & pend_r & gap_ok;
    wire div_wrap = (div_r == `TSR_SCLK_HALF - 3'h0_001);
    wire rise     = div_wrap & ~sclk_r;
    wire last_fal = div_wrap & sclk_r
                  & (edge_cnt_r == `TSR_FRAME_CLKS);           // [R03]

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r <= tsr_pkg::TSR_HST_IDLE;
            div_r   <= 3'h0_000;
            sclk_r  <= 1'b0;
            sel_n_r <= 1'b1;
        end else begin
            unique case (state_r)
                tsr_pkg::TSR_HST_IDLE: begin
                    if (go) begin
                        state_r <= tsr_pkg::TSR_HST_LEAD;
                        sel_n_r <= 1'b0;
                        div_r   <= 3'h0_000;
                    end
                end
                tsr_pkg::TSR_HST_LEAD: begin
                    div_r <= div_r + 3'h0_001;
                    if (div_r == `TSR_EDGE_GAP - 3'h0_001) begin
                        state_r <= tsr_pkg::TSR_HST_SHIFT;
                        div_r   <= 3'h0_000;
                    end
                end
                tsr_pkg::TSR_HST_SHIFT: begin
                    div_r <= div_wrap ? 3'h0_000 : div_r + 3'h0_001;
                    if (div_wrap) begin
                        sclk_r <= ~sclk_r;
                    end
                    if (last_fal) begin
                        state_r <= tsr_pkg::TSR_HST_TAIL;
                    end
                end
                tsr_pkg::TSR_HST_TAIL: begin
                    div_r <= div_r + 3'h0_001;
                    if (div_r == `TSR_EDGE_GAP - 3'h0_001) begin
                        state_r <= tsr_pkg::TSR_HST_IDLE;
                        sel_n_r <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Bits are sampled from the synchronised line at the rising edge
    // the host makes; the half period covers the two-stage delay.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            edge_cnt_r <= 5'h0_000;
            raw_r      <= 16'h0_000;
        end else if (go) begin
            edge_cnt_r <= 5'h0_000;
        end else if (state_r == tsr_pkg::TSR_HST_SHIFT && rise) begin
            edge_cnt_r <= edge_cnt_r + 5'h0_001;
            raw_r      <= {raw_r[14:0], sdo_s};                // [R16]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            gap_r <= GAP_LAST;
        end else if (go) begin
            gap_r <= 15'h0_000;                                // [R15]
        end else if (!gap_ok) begin
            gap_r <= gap_r + 15'h0_001;
        end
    end

    // A new start wins over go, and a frame end over a clear, in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pend_r  <= 1'b0;
            done_r  <= 1'b0;
            frame_r <= 16'h0_000;
        end else begin
            pend_r <= wr_start | (pend_r & ~go);
            if (state_r == tsr_pkg::TSR_HST_TAIL
                && div_r == `TSR_EDGE_GAP - 3'h0_001) begin
                done_r  <= 1'b1;
                frame_r <= raw_r;
            end else if (wr_clr) begin
                done_r <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    wire [31:0] stat_word = {28'h000_0000, pend_r, gap_ok, done_r, ~idle};
    wire [31:0] data_word = {frame_r, 6'h0_00, frame_r[14:5]};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup) begin
            prdata_r <= hit_stat ? stat_word :
                        hit_data ? data_word : 32'h0000_0000;
        end
    end

    assign prdata             = prdata_r;
    assign pready             = 1'b1;
    assign pslverr            = access & ~hit;
    assign link.sclk          = sclk_r;
    assign link.temp_select_n = sel_n_r;                       // [R17]
    assign link.din           = 1'b0;                          // [R06]

endmodule : tsr_host

//--- dv/tsr_monitor.sv
`timescale 1ns/1ns
// ************************************************************
// Link checker
// ************************************************************
module tsr_monitor #(
    parameter int unsigned GAP_CYC = 300
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Link signals
    input wire logic sclk,
    input wire logic temp_select_n,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe_n,
    input wire logic sdo
);
    logic        sclk_d_r;
    logic        sel_d_r;
    logic [4:0]  edges_r;
    int unsigned gap_r;
    wire         sclk_rise = sclk && !sclk_d_r;
    wire         sel_fall  = sel_d_r && !temp_select_n;

    always_ff @(posedge sys_clk) begin
        sclk_d_r <= sys_rst ? 1'b0 : sclk;
        sel_d_r  <= sys_rst ? 1'b1 : temp_select_n;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || temp_select_n) begin
            edges_r <= 5'h00;
        end else if (sclk_rise) begin
            edges_r <= edges_r + 5'h01;
        end
    end

    // Saturates, so a long idle link never wraps into a false short gap.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            gap_r <= GAP_CYC;
        end else if (sel_fall) begin
            gap_r <= 0;
        end else if (gap_r < GAP_CYC) begin
            gap_r <= gap_r + 1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence sclk_high_s;
        sclk [*4] ##1 !sclk;
    endsequence
    sequence lead_s;
        !sclk [*8] ##1 sclk;
    endsequence

    oe_follow_a: assert property (dout_oe_n == temp_select_n)
        else $error("data enable differs from select");
    idle_clock_a: assert property (temp_select_n |-> !sclk)
        else $error("link clock moves while deselected");
    din_low_a: assert property (!din)
        else $error("serial input not low");
    lead_zero_a: assert property ($fell(temp_select_n) |-> !sdo [*8])
        else $error("leading bit not zero");
    pulse_count_a: assert property (
        $rose(temp_select_n) |-> edges_r == 5'h10)
        else $error("frame without sixteen clock pulses");
    sclk_shape_a: assert property ($rose(sclk) |-> sclk_high_s)
        else $error("clock high phase wrong");
    frame_lead_a: assert property ($fell(temp_select_n) |-> lead_s)
        else $error("clock start after select wrong");
    last_hold_a: assert property (
        (edges_r >= 5'd11 && !temp_select_n)
        |=> (temp_select_n || $stable(dout)))
        else $error("data moved after last result bit");
    gap_space_a: assert property (
        $fell(temp_select_n) |-> gap_r + 1 >= GAP_CYC)
        else $error("select falls too close together");
endmodule : tsr_monitor

//--- dv/tb_temp_sensor_serial_readout.sv
`timescale 1ns/1ns
`include "tsr_regs.svh"
// ************************************************************
// Bench
// ************************************************************
module tb_temp_sensor_serial_readout;
    localparam int unsigned GAP = 300;
    logic               sys_clk;
    logic               sys_rst;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [7:0]         paddr;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    tsr_pkg::tsr_temp_t temp_in;
    tsr_pkg::tsr_temp_t result;
    logic [7:0]         ctrl_word;
    logic               conv_busy;
    logic               lockout;
    logic               saw_lock;
    logic [31:0]        rd;
    logic [31:0]        d;
    logic               err;
    int                 n_errors;
    int                 cmp_count;
    int                 cycles;
    tsr_pkg::tsr_temp_t vals [4] = '{10'h3FF, 10'h001, 10'h360, 10'h1F4};

    tsr_if link_if ();
    tsr_dev #(.PERIOD_CYC(200)) tsr_dev_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link_if),
        .temp_in(temp_in), .result(result), .ctrl_word(ctrl_word),
        .conv_busy(conv_busy), .lockout(lockout));
    tsr_host #(.GAP_CYC(GAP)) tsr_host_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link_if),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    tsr_monitor #(.GAP_CYC(GAP)) tsr_monitor_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .sclk(link_if.sclk),
        .temp_select_n(link_if.temp_select_n), .din(link_if.din),
        .dout(link_if.dout), .dout_oe_n(link_if.dout_oe_n),
        .sdo(link_if.sdo));

    always #20 sys_clk = ~sys_clk;

    // The ceiling allows roughly three and a half times the expected run.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (lockout === 1'b1) begin
            saw_lock <= 1'b1;
        end
        if (cycles == 20000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic frame(output logic [31:0] q);
        int n;
        apb(1'b1, `TSR_OFS_CTRL, 32'h0000_0001);
        n = 0;
        do begin
            apb(1'b0, `TSR_OFS_STATUS, 32'h0);
            n++;
        end while (rd[`TSR_ST_DONE_BIT] !== 1'b1 && n < 1000);
        apb(1'b0, `TSR_OFS_DATA, 32'h0);
        q = rd;
        apb(1'b1, `TSR_OFS_STATUS, 32'h0000_0002);
    endtask : frame

    task automatic data_check(input logic [31:0] q,
                              input tsr_pkg::tsr_temp_t v);
        check({16'h0000, q[31:16]}, {16'h0000, 1'b0, v, {5{v[0]}}});
        check({22'h00_0000, q[9:0]}, {22'h00_0000, v});
    endtask : data_check

    initial begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        temp_in = 10'h000;
        saw_lock = 1'b0;
        n_errors = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        apb(1'b0, `TSR_OFS_DATA, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        check({31'h0, err}, 32'h1);
        foreach (vals[i]) begin
            temp_in <= vals[i];
            repeat (900) @(posedge sys_clk);
            check({22'h00_0000, result}, {22'h00_0000, vals[i]});
            frame(d);
            data_check(d, vals[i]);
            check({24'h00_0000, ctrl_word}, 32'h0);
        end
        // A read squeezed into the restarted conversion sees old data.
        saw_lock <= 1'b0;
        temp_in <= 10'h064;
        frame(d);
        data_check(d, vals[3]);
        check({31'h0, saw_lock}, 32'h1);
        repeat (900) @(posedge sys_clk);
        frame(d);
        data_check(d, 10'h064);
        apb(1'b0, `TSR_OFS_STATUS, 32'h0);
        check({31'h0, rd[`TSR_ST_DONE_BIT]}, 32'h0);
        finish_test();
    end
endmodule : tb_temp_sensor_serial_readout
